// ### logic/acs_pkg.sv
// Purpose: shared constants and types for the conversion sequencer
// Assumes: 50 MHz cpu clock, converter clock made by power-of-two division
// Notes: conversion timing is counted in half converter clock cycles
package acs_pkg;

	// ------------------------------------------------------------
	// widths and encodings
	// ------------------------------------------------------------
	localparam int RES_W = 10;
	localparam int CHAN_W = 4;
	localparam int PRESC_W = 7;
	localparam logic [2:0] TRIG_SEL_SELF = 3'h0;
	localparam logic [2:0] PRESC_TOP_SEL = 3'h7;
	localparam logic [PRESC_W-1:0] PRESC_FULL = 7'h7F;
	localparam logic FIRST_RESET = 1'b1;

	// ------------------------------------------------------------
	// timing in half converter cycles
	// ------------------------------------------------------------
	localparam logic [5:0] LEN_NORMAL = 6'h1A;
	localparam logic [5:0] SMP_NORMAL = 6'h03;
	localparam logic [5:0] LEN_FIRST = 6'h32;
	localparam logic [5:0] SMP_FIRST = 6'h1B;
	localparam logic [5:0] LEN_AUTO = 6'h1B;
	localparam logic [5:0] SMP_AUTO = 6'h04;
	localparam logic [5:0] LEN_FREE = 6'h1C;
	localparam logic [5:0] SMP_FREE = 6'h05;
	localparam logic [5:0] LAST_CYCLE_HALVES = 6'h02;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ACS_IDLE = 2'b00,
		ACS_WAIT = 2'b01,
		ACS_CONV = 2'b11
	} acs_state_type;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_FIRST = 2'b01,
		MODE_AUTO = 2'b10,
		MODE_FREE = 2'b11
	} acs_mode_type;

	typedef struct packed {
		logic [5:0] len;
		logic [5:0] sample;
	} acs_timing_type;

	typedef struct packed {
		logic enable;
		logic auto_trigger_enable;
		logic [2:0] trigger_select;
		logic [2:0] prescale_select;
		logic left_adjust;
		logic reference_select;
		logic [CHAN_W-1:0] channel_select;
	} acs_ctrl_type;

	typedef struct packed {
		logic power;
		logic reference;
		logic [CHAN_W-1:0] channel;
		logic sample_hold;
		logic converting;
	} acs_analog_type;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic acs_timing_type acs_timing(input acs_mode_type m);
		acs_timing_type t;
		unique case (m)
			MODE_NORMAL: t = '{len: LEN_NORMAL, sample: SMP_NORMAL};
			MODE_FIRST: t = '{len: LEN_FIRST, sample: SMP_FIRST};
			MODE_AUTO: t = '{len: LEN_AUTO, sample: SMP_AUTO};
			MODE_FREE: t = '{len: LEN_FREE, sample: SMP_FREE};
		endcase
		return t;
	endfunction

	// last count of one converter period; settings 0 and 1 both divide by 2
	function automatic logic [PRESC_W-1:0] acs_presc_last(input logic [2:0] sel);
		logic [2:0] eff;
		eff = (sel == 3'h0) ? 3'h1 : sel;
		return PRESC_FULL >> (PRESC_TOP_SEL - eff);
	endfunction

endpackage

// ### logic/acs_prescaler.sv
// Purpose: converter clock prescaler giving rise and fall ticks
// Assumes: run follows the converter enable
// Notes: ticks are combinational from the registered count
`timescale 1ns/1ps
module acs_prescaler import acs_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic restart,
	input wire logic [2:0] prescale_select,
	output logic tick_rise,
	output logic tick_fall
);

	typedef struct packed {
		logic [PRESC_W-1:0] cnt;
	} acs_presc_type;

	acs_presc_type r_reg;
	acs_presc_type r_next;
	logic [PRESC_W-1:0] last;

	assign last = acs_presc_last(prescale_select);
	assign tick_rise = run && !restart && (r_reg.cnt == last);
	assign tick_fall = run && !restart && (r_reg.cnt == (last >> 1));

	always_comb begin
		r_next = r_reg;
		// held at zero while disabled, restarted by a trigger
		if (!run || restart) begin
			r_next.cnt = '0;
		end else if (r_reg.cnt == last) begin
			r_next.cnt = '0;
		end else begin
			r_next.cnt = r_reg.cnt + 7'h01;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	held_off_a: assert property (!run |=> r_reg.cnt == '0)
		else $error("prescaler counted while disabled");
	restart_zero_a: assert property (run && restart |=> r_reg.cnt == '0 && !tick_rise)
		else $error("prescaler not restarted by trigger");

endmodule // acs_prescaler

// ### logic/acs_result.sv
// Purpose: result byte pair with read lock and justification
// Assumes: low and high read strobes are one-cycle pulses
// Notes: lock set by low read, cleared by high read
`timescale 1ns/1ps
module acs_result import acs_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic done,
	input wire logic [RES_W-1:0] code,
	input wire logic left_adjust,
	input wire logic result_low_read,
	input wire logic result_high_read,
	output logic [7:0] result_low_byte,
	output logic [7:0] result_high_byte
);

	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
		logic locked;
	} acs_res_type;

	acs_res_type r_reg;
	acs_res_type r_next;

	assign result_low_byte = r_reg.lo;
	assign result_high_byte = r_reg.hi;

	always_comb begin
		r_next = r_reg;
		if (result_high_read) begin
			r_next.locked = 1'b0;
		end
		if (result_low_read) begin
			r_next.locked = 1'b1;
		end
		// a blocked completion is dropped whole
		if (done && !r_reg.locked) begin
			if (left_adjust) begin
				r_next.hi = code[9:2];
				r_next.lo = {code[1:0], 6'h00};
			end else begin
				r_next.hi = {6'h00, code[9:8]};
				r_next.lo = code[7:0];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	blocked_hold_a: assert property (r_reg.locked && done |=> $stable(r_reg.lo) && $stable(r_reg.hi))
		else $error("result changed while blocked");
	right_adjust_a: assert property (done && !r_reg.locked && !left_adjust |=> r_reg.hi[7:2] == 6'h00 && r_reg.lo == $past(code[7:0]))
		else $error("right justified result wrong");

endmodule // acs_result

// ### logic/acs_sequencer.sv
// Purpose: conversion sequencer for a 10-bit successive-approximation converter
// Assumes: analog array delivers its code on analog_code by completion
// Notes: control bits arrive as plain ports in one struct
`timescale 1ns/1ps
module acs_sequencer import acs_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic converter_power_reduce,
	input wire acs_ctrl_type ctrl,
	input wire logic start_write,
	input wire logic [7:0] trigger_sources,
	input wire logic done_flag_clear,
	input wire logic result_low_read,
	input wire logic result_high_read,
	input wire logic [RES_W-1:0] analog_code,
	output logic start_conversion,
	output logic conversion_done_flag,
	output logic conversion_done,
	output logic [7:0] result_low_byte,
	output logic [7:0] result_high_byte,
	output acs_analog_type analog
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		acs_state_type state;
		acs_mode_type mode;
		logic [5:0] hcnt;
		logic first;
		logic en;
		logic trig_s1;
		logic trig_s2;
		logic trig_prev;
		logic done_flag;
		logic done_pulse;
		logic sample_pulse;
		logic ref_applied;
		logic [CHAN_W-1:0] chan_applied;
	} acs_seq_type;

	acs_seq_type r_reg;
	acs_seq_type r_next;

	logic en;
	logic self_trig;
	logic trig_edge;
	logic auto_start;
	logic tick_rise;
	logic tick_fall;
	logic tick;
	logic [5:0] hcnt_inc;
	acs_timing_type timing;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// power reduction overrides the enable outright
	assign en = ctrl.enable && !converter_power_reduce;
	assign self_trig = ctrl.trigger_select == TRIG_SEL_SELF;
	// two sync flops plus edge register: three clocks of latency
	assign trig_edge = r_reg.trig_s2 && !r_reg.trig_prev;
	assign auto_start = en && ctrl.auto_trigger_enable && !self_trig
		&& trig_edge && (r_reg.state == ACS_IDLE);
	assign tick = tick_rise || tick_fall;
	assign hcnt_inc = r_reg.hcnt + 6'h01;
	assign timing = acs_timing(r_reg.mode);

	// ------------------------------------------------------------
	// prescaler
	// ------------------------------------------------------------
	acs_prescaler u_prescaler (
		.clk(clk),
		.reset(reset),
		.run(en),
		.restart(auto_start),
		.prescale_select(ctrl.prescale_select),
		.tick_rise(tick_rise),
		.tick_fall(tick_fall)
	);

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.en = en;
		r_next.done_pulse = 1'b0;
		r_next.sample_pulse = 1'b0;
		r_next.trig_s1 = trigger_sources[ctrl.trigger_select];
		r_next.trig_s2 = r_reg.trig_s1;
		r_next.trig_prev = r_reg.trig_s2;
		if (done_flag_clear) begin
			r_next.done_flag = 1'b0;
		end
		if (!en) begin
			// disabling aborts and rearms the long first conversion
			r_next.state = ACS_IDLE;
			r_next.hcnt = '0;
			r_next.first = 1'b1;
		end else begin
			unique case (r_reg.state)
				ACS_IDLE: begin
					if (start_write) begin
						r_next.state = ACS_WAIT;
					end else if (auto_start) begin
						r_next.state = ACS_CONV;
						// a trigger can also start the long first conversion
						r_next.mode = r_reg.first ? MODE_FIRST : MODE_AUTO;
						r_next.hcnt = '0;
					end
				end
				ACS_WAIT: begin
					if (tick_rise) begin
						r_next.state = ACS_CONV;
						r_next.mode = r_reg.first ? MODE_FIRST : MODE_NORMAL;
						r_next.hcnt = '0;
					end
				end
				ACS_CONV: begin
					if (tick) begin
						r_next.hcnt = hcnt_inc;
						if (hcnt_inc == timing.sample) begin
							r_next.sample_pulse = 1'b1;
						end
						if (hcnt_inc == timing.len) begin
							// flag rises even if the result bytes are locked
							r_next.done_pulse = 1'b1;
							r_next.first = 1'b0;
							r_next.hcnt = '0;
							if (ctrl.auto_trigger_enable && self_trig) begin
								r_next.mode = MODE_FREE;
							end else begin
								r_next.state = ACS_IDLE;
							end
						end
					end
				end
				default: begin
					r_next.state = ACS_IDLE;
				end
			endcase
		end
		// set wins over a clear in the same cycle
		if (r_next.done_pulse) begin
			r_next.done_flag = 1'b1;
		end
		// selection buffer: frozen during conversion except its last cycle
		if (en && (r_reg.state != ACS_CONV
			|| r_reg.hcnt + LAST_CYCLE_HALVES >= timing.len)) begin
			r_next.ref_applied = ctrl.reference_select;
			r_next.chan_applied = ctrl.channel_select;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r_reg <= '0;
			r_reg.first <= FIRST_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------
	// result bytes
	// ------------------------------------------------------------
	acs_result u_result (
		.clk(clk),
		.reset(reset),
		.done(r_reg.done_pulse),
		.code(analog_code),
		.left_adjust(ctrl.left_adjust),
		.result_low_read(result_low_read),
		.result_high_read(result_high_read),
		.result_low_byte(result_low_byte),
		.result_high_byte(result_high_byte)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// start bit reads one from request until a completion that returns to idle, any start path
	assign start_conversion = r_reg.state != ACS_IDLE;
	assign conversion_done_flag = r_reg.done_flag;
	assign conversion_done = r_reg.done_pulse;
	assign analog.power = r_reg.en;
	assign analog.reference = r_reg.ref_applied;
	assign analog.channel = r_reg.chan_applied;
	assign analog.sample_hold = r_reg.sample_pulse;
	assign analog.converting = r_reg.state == ACS_CONV;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	done_clears_start_a: assert property (
		r_reg.done_pulse && r_reg.mode != MODE_FREE |-> !start_conversion && r_reg.done_flag)
		else $error("completion did not clear start and set flag");
	flag_set_wins_a: assert property (
		r_next.done_pulse && done_flag_clear |=> conversion_done_flag)
		else $error("completion flag lost to clear");
	rise_start_a: assert property (
		en && r_reg.state == ACS_WAIT && tick_rise |=> r_reg.state == ACS_CONV && r_reg.hcnt == 6'h00)
		else $error("conversion did not begin on converter rise");
	conv_length_a: assert property (
		r_reg.state == ACS_CONV |-> r_reg.hcnt < timing.len)
		else $error("conversion ran past its length");
	first_length_a: assert property (
		r_reg.first && r_reg.state != ACS_CONV && r_next.state == ACS_CONV |=> r_reg.mode == MODE_FIRST)
		else $error("first conversion after enable not long");
	sample_point_a: assert property (
		r_reg.sample_pulse |-> r_reg.hcnt == timing.sample && r_reg.state == ACS_CONV)
		else $error("sample at wrong point");
	select_frozen_a: assert property (
		r_reg.state == ACS_CONV && r_reg.hcnt + LAST_CYCLE_HALVES < timing.len
		&& !r_reg.done_pulse |=> $stable(r_reg.chan_applied) && $stable(r_reg.ref_applied))
		else $error("selection changed mid conversion");
	select_disabled_a: assert property (
		!en |=> $stable(r_reg.chan_applied))
		else $error("selection applied while disabled");
	edge_ignored_a: assert property (
		r_reg.state == ACS_CONV && trig_edge && !tick |=> r_reg.hcnt == $past(r_reg.hcnt))
		else $error("trigger edge disturbed a conversion");
	auto_begin_a: assert property (
		auto_start && !start_write && !r_reg.first |=> r_reg.state == ACS_CONV
		&& r_reg.mode == MODE_AUTO
		&& start_conversion)
		else $error("trigger edge did not start a conversion");
	free_run_a: assert property (
		r_reg.state == ACS_CONV && tick && hcnt_inc == timing.len && en
		&& ctrl.auto_trigger_enable && self_trig |=> start_conversion && r_reg.mode == MODE_FREE)
		else $error("free running did not restart");
	disable_idle_a: assert property (
		!en |=> r_reg.state == ACS_IDLE && !start_conversion)
		else $error("sequencer active while disabled");

	// ------------------------------------------------------------
	// checks: start paths and refusals
	// ------------------------------------------------------------
	start_take_a: assert property (
		en && r_reg.state == ACS_IDLE && start_write
		|=> r_reg.state == ACS_WAIT && start_conversion)
		else $error("start write not taken");
	wait_hold_a: assert property (
		en && r_reg.state == ACS_WAIT && !tick_rise
		|=> r_reg.state == ACS_WAIT && !analog.converting)
		else $error("conversion began off the converter rise");
	conv_entry_a: assert property (
		$rose(analog.converting)
		|-> $past(tick_rise) || $past(auto_start))
		else $error("conversion began without rise or trigger");
	idle_stays_a: assert property (
		en && r_reg.state == ACS_IDLE && !start_write && !trig_edge
		|=> r_reg.state == ACS_IDLE)
		else $error("conversion began without an edge");
	self_needs_start_a: assert property (
		en && r_reg.state == ACS_IDLE && ctrl.auto_trigger_enable && self_trig
		&& !start_write |=> r_reg.state == ACS_IDLE)
		else $error("free running began without start bit");
	start_refused_a: assert property (
		en && r_reg.state == ACS_CONV && start_write && !tick
		|=> r_reg.state == ACS_CONV && r_reg.hcnt == $past(r_reg.hcnt))
		else $error("start write disturbed a conversion");
	power_gate_a: assert property (
		converter_power_reduce
		|=> !analog.power && !start_conversion)
		else $error("converter active while power reduced");

	// ------------------------------------------------------------
	// checks: flag, counts and selections
	// ------------------------------------------------------------
	first_rearm_a: assert property (
		!en
		|=> r_reg.first)
		else $error("first conversion not rearmed by disable");
	done_flag_a: assert property (
		r_reg.done_pulse
		|-> conversion_done_flag)
		else $error("completion without flag");
	flag_sticky_a: assert property (
		conversion_done_flag && !done_flag_clear
		|=> conversion_done_flag)
		else $error("completion flag dropped without clear");
	flag_clear_a: assert property (
		done_flag_clear && !r_next.done_pulse
		|=> !conversion_done_flag)
		else $error("completion flag not cleared");
	sample_once_a: assert property (
		r_reg.sample_pulse
		|=> !r_reg.sample_pulse)
		else $error("sample pulse longer than one cycle");
	done_once_a: assert property (
		r_reg.done_pulse
		|=> !r_reg.done_pulse)
		else $error("completion pulse longer than one cycle");
	sample_not_done_a: assert property (
		r_reg.sample_pulse
		|-> !r_reg.done_pulse)
		else $error("sample and completion together");
	select_follow_a: assert property (
		en && r_reg.state == ACS_IDLE |=> r_reg.chan_applied == $past(ctrl.channel_select)
		&& r_reg.ref_applied == $past(ctrl.reference_select))
		else $error("selection did not follow while idle");
	tick_apart_a: assert property (
		tick_rise
		|-> !tick_fall ##1 !tick_rise)
		else $error("converter clock edges too close");
	no_tick_off_a: assert property (
		!en
		|-> !tick)
		else $error("converter clock ran while disabled");
	hcnt_step_a: assert property (
		en && r_reg.state == ACS_CONV && tick && hcnt_inc != timing.len
		|=> r_reg.hcnt == $past(hcnt_inc))
		else $error("conversion count skipped");

endmodule // acs_sequencer

// ### bench/acs_analog_model.sv
// Purpose: stand-in for the analog array behind the sequencer
// Assumes: sample_hold is a one-cycle pulse from the sequencer
// Notes: the code packs channel, reference and a bench level
`timescale 1ns/1ps
module acs_analog_model import acs_pkg::*; (
	input wire logic clk,
	input wire acs_analog_type analog,
	input wire logic [4:0] level,
	output logic [RES_W-1:0] analog_code
);
	// ------------------------------------------------------------
	// sample and hold
	// ------------------------------------------------------------
	logic [RES_W-1:0] held_reg = '0;

	// ideal array: resolves at any converter clock rate
	// code tells the bench which channel and reference were really sampled
	always_ff @(posedge clk) begin
		if (analog.sample_hold) begin
			held_reg <= {analog.channel, analog.reference, level};
		end
	end

	// unpowered array gives no valid code, so show a wrong one
	always_comb begin
		analog_code = analog.power ? held_reg : ~held_reg;
	end
endmodule // acs_analog_model

// ### bench/tb.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: half converter period is 2^max(sel,1)/2 clocks
// Notes: lengths are checked to two clocks, tick alignment is loose
`timescale 1ns/1ps
module tb import acs_pkg::*;;
	logic clk, reset, converter_power_reduce, start_write, done_flag_clear;
	logic result_low_read, result_high_read, start_conversion;
	logic conversion_done_flag, conversion_done, conv_prev;
	logic [7:0] trigger_sources, result_low_byte, result_high_byte;
	logic [4:0] level;
	logic [9:0] exp_code;
	logic [15:0] held;
	logic [RES_W-1:0] analog_code;
	acs_ctrl_type ctrl;
	acs_analog_type analog;
	int n_mismatch = 0;
	int compares = 0;
	int seed = 32'h8627;
	int half, cnt, last_len, last_smp, k;

	acs_sequencer u_dut (.clk, .reset, .converter_power_reduce, .ctrl, .start_write,
		.trigger_sources, .done_flag_clear, .result_low_read, .result_high_read,
		.analog_code, .start_conversion, .conversion_done_flag, .conversion_done,
		.result_low_byte, .result_high_byte, .analog);
	acs_analog_model u_analog (.clk, .analog, .level, .analog_code);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ------------------------------------------------------------
	// timing monitor
	// ------------------------------------------------------------
	// counts from conversion start or previous completion
	always @(posedge clk) begin
		cnt = cnt + 1;
		if (conversion_done === 1'b1) begin
			last_len = cnt;
			cnt = 0;
		end
		if (analog.converting === 1'b1 && conv_prev !== 1'b1) cnt = 0;
		if (analog.sample_hold === 1'b1) last_smp = cnt;
		conv_prev = analog.converting;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	function automatic logic [15:0] bytes_of(logic [9:0] c, logic left);
		return left ? {c, 6'h00} : {6'h00, c};
	endfunction

	task automatic check_bits(string name, logic [15:0] exp, logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_time(string name, int exp, int got);
		compares++;
		if (got < exp - 2 || got > exp + 2) begin
			n_mismatch++;
			$display("ERROR %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic pulse(int which);
		@(posedge clk);
		case (which)
			0: start_write <= 1'b1;
			1: done_flag_clear <= 1'b1;
			2: result_low_read <= 1'b1;
			default: result_high_read <= 1'b1;
		endcase
		@(posedge clk);
		{start_write, done_flag_clear, result_low_read, result_high_read} <= 4'h0;
	endtask

	task automatic wait_done;
		int n;
		for (n = 0; n < 20000; n++) begin
			@(posedge clk);
			#1;
			if (conversion_done === 1'b1) break;
		end
		check_bits("completion seen", 1, conversion_done);
	endtask

	task automatic setup(logic left);
		@(posedge clk);
		ctrl.left_adjust <= left;
		ctrl.reference_select <= 1'($random(seed));
		ctrl.channel_select <= 4'($random(seed));
		level <= 5'($random(seed));
		repeat (2) @(posedge clk);
		exp_code = {ctrl.channel_select, ctrl.reference_select, level};
		#1 check_bits("channel follows", ctrl.channel_select, analog.channel);
	endtask

	task automatic convert(int len_t, int smp_t, int new_ch);
		logic [3:0] old_ch;
		old_ch = analog.channel;
		pulse(0);
		#1 check_bits("start bit", 1, start_conversion);
		if (new_ch >= 0) begin
			repeat (12 * half) @(posedge clk);
			ctrl.channel_select <= 4'(new_ch);
			repeat (2) @(posedge clk);
			#1 check_bits("frozen channel", old_ch, analog.channel);
		end
		wait_done;
		check_bits("start bit at done", 0, start_conversion);
		check_bits("done flag", 1, conversion_done_flag);
		@(posedge clk);
		#1 check_time("length", len_t * half, last_len);
		check_time("sample point", smp_t * half, last_smp);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		reset = 1'b1;
		converter_power_reduce = 1'b1;
		{start_write, done_flag_clear, result_low_read, result_high_read} = 4'h0;
		ctrl = '0;
		trigger_sources = 8'h00;
		level = 5'h00;
		half = 4;
		cnt = 0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		ctrl.enable <= 1'b1;
		ctrl.prescale_select <= 3'h3;
		ctrl.channel_select <= 4'h5;
		pulse(0);
		repeat (4) @(posedge clk);
		#1 check_bits("start unpowered", 0, start_conversion);
		check_bits("channel unpowered", 0, analog.channel);
		@(posedge clk);
		converter_power_reduce <= 1'b0;
		setup(1'b0);
		convert(50, 27, -1);
		check_bits("result", bytes_of(exp_code, 1'b0), {result_high_byte, result_low_byte});
		for (k = 0; k < 4; k++) begin
			setup(k[0]);
			convert(26, 3, -1);
			check_bits("result", bytes_of(exp_code, k[0]), {result_high_byte, result_low_byte});
		end
		$display("test single conversions done");
		held = bytes_of(exp_code, 1'b1);
		pulse(1);
		#1 check_bits("flag cleared", 0, conversion_done_flag);
		pulse(2);
		setup(1'b1);
		convert(26, 3, -1);
		check_bits("locked result", held, {result_high_byte, result_low_byte});
		pulse(3);
		setup(1'b1);
		convert(26, 3, -1);
		check_bits("unlocked result", bytes_of(exp_code, 1'b1), {result_high_byte, result_low_byte});
		setup(1'b0);
		convert(26, 3, 9);
		check_bits("old channel result", bytes_of(exp_code, 1'b0), {result_high_byte, result_low_byte});
		check_bits("channel resumed", 9, analog.channel);
		$display("test lock and channel done");
		for (k = 0; k < 8; k++) begin
			@(posedge clk);
			ctrl.prescale_select <= 3'(k);
			half = (k < 2) ? 1 : (1 << (k - 1));
			convert(26, 3, -1);
		end
		$display("test prescaler done");
		@(posedge clk);
		ctrl.prescale_select <= 3'h3;
		ctrl.auto_trigger_enable <= 1'b1;
		ctrl.trigger_select <= 3'h3;
		trigger_sources <= 8'($random(seed)) & 8'hF7;
		half = 4;
		repeat (20) @(posedge clk);
		#1 check_bits("other sources", 0, start_conversion);
		@(posedge clk);
		trigger_sources[3] <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (analog.converting !== 1'b1 && k < 20);
		check_time("trigger delay", 4, k);
		wait_done;
		@(posedge clk);
		#1 check_time("auto length", 27 * half, last_len);
		check_time("auto sample", 4 * half, last_smp);
		repeat (60 * half) @(posedge clk);
		#1 check_bits("held trigger", 0, start_conversion);
		@(posedge clk);
		trigger_sources[3] <= 1'b0;
		pulse(0);
		repeat (8 * half) @(posedge clk);
		trigger_sources[3] <= 1'b1;
		#1 check_bits("start bit under auto", 1, start_conversion);
		wait_done;
		repeat (60 * half) @(posedge clk);
		#1 check_bits("edge in conversion", 0, start_conversion);
		$display("test auto trigger done");
		@(posedge clk);
		trigger_sources <= 8'h00;
		ctrl.trigger_select <= TRIG_SEL_SELF;
		pulse(0);
		for (k = 0; k < 3; k++) begin
			wait_done;
			@(posedge clk);
			#1 check_bits("start bit kept", 1, start_conversion);
			if (k > 0) check_time("free length", 28 * half, last_len);
			if (k > 0) check_time("free sample", 5 * half, last_smp);
		end
		@(posedge clk);
		ctrl.enable <= 1'b0;
		repeat (4) @(posedge clk);
		#1 check_bits("disable stops", 0, start_conversion);
		@(posedge clk);
		ctrl.enable <= 1'b1;
		ctrl.auto_trigger_enable <= 1'b0;
		setup(1'b1);
		convert(50, 27, -1);
		check_bits("result", bytes_of(exp_code, 1'b1), {result_high_byte, result_low_byte});
		$display("test free running done");
		give_verdict;
	end

	initial begin
		repeat (50000) @(posedge clk);
		n_mismatch++;
		$display("ERROR watchdog expected finish seen timeout");
		give_verdict;
	end
endmodule // tb
